// ---- pkg/rst_ctrl_pkg.sv ----
// Constants for the reset controller: register map, fields, reset values.
// Assumes a 100 MHz pclk and an APB master with 32-bit data.
package rst_ctrl_pkg;
    // Register byte addresses
    localparam logic [15:0] ADDR_WDOG_SEC = 16'h1ff0;
    localparam logic [15:0] ADDR_MASK_OPT = 16'h1f00;
    localparam logic [15:0] ADDR_STATUS = 16'h1f04;
    localparam logic [15:0] ADDR_PERIPH = 16'h1f08;
    // Watchdog and security register fields
    localparam int WS_CLEAR = 0;
    localparam int WS_OPT = 1;
    localparam int WS_PROTECT = 2;
    // Mask option register fields
    localparam int MO_LONG_DELAY = 0;
    localparam int MO_WDOG_EN = 1;
    localparam int MO_UV_EN = 2;
    localparam logic [2:0] MASK_OPT_RESET = 3'h7;
    // Status register fields: sticky causes, then live state
    localparam int ST_POR = 0;
    localparam int ST_PIN = 1;
    localparam int ST_WDOG = 2;
    localparam int ST_UV = 3;
    localparam int ST_ILLEGAL = 4;
    localparam int ST_IN_RESET = 8;
    localparam int ST_PULLDOWN = 9;
    // Peripheral configuration fields
    localparam int PC_OSC_LOW = 0;
    localparam int PC_OSC_HIGH = 1;
    localparam int PC_IRQ_EN = 2;
    localparam int PC_RTI_LO = 3;
    localparam int PC_RTI_HI = 4;
    localparam logic [4:0] PERIPH_RESET = 5'h1e;
    // Startup delays in bus cycles
    localparam logic [11:0] DELAY_SHORT = 12'h010;
    localparam logic [11:0] DELAY_LONG = 12'hfe0;
    // Pulldown stretch: three cycles plus the registered edge
    localparam logic [1:0] PULL_CYCLES = 2'h3;
    // Legal opcode fetch windows
    localparam logic [15:0] PROG_LO = 16'h0700;
    localparam logic [15:0] PROG_HI = 16'h1fff;
    localparam logic [15:0] RAM_LO = 16'h0020;
    localparam logic [15:0] RAM_HI = 16'h00ff;
    // Values handed to CPU and peripherals while in reset
    localparam logic [7:0] SP_RESET = 8'hff;
    localparam logic [15:0] VECTOR_HI_ADDR = 16'h1ffe;
    localparam logic [15:0] VECTOR_LO_ADDR = 16'h1fff;
    localparam logic [15:0] TIMER_PRESET = 16'hfffc;
    localparam logic [7:0] ANALOG_MUX_REGISTER_RESET = 8'h80;
    localparam logic [7:0] CLEARED = 8'h00;
    // Reset sequencing states, Gray coded
    typedef enum logic [1:0] {
        RS_POR_WAIT = 2'b00,
        RS_HOLD = 2'b01,
        RS_RUN = 2'b11
    } rst_state_t;
endpackage : rst_ctrl_pkg

// ---- src/pull_stretch.sv ----
// Pulldown stretcher for one reset source.
// Assumes a source level that is synchronous to pclk.
`timescale 1ns/1ps
module pull_stretch (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic src,
    output logic pull
);
    logic src_q;
    logic src_d;
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;

    // Load on the rising edge, count down afterwards
    always_comb begin
        src_d = src;
        cnt_d = cnt_q;
        if (src && !src_q) begin
            cnt_d = rst_ctrl_pkg::PULL_CYCLES;
        end else if (cnt_q != 2'h0) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            src_q <= src_d;
            cnt_q <= cnt_d;
        end
    end

    // Longer of source duration and the count
    assign pull = src | (cnt_q != 2'h0);
endmodule : pull_stretch

// ---- src/mcu_reset_control.sv ----
// Reset controller of a small microcontroller with an APB register port.
// Assumes all inputs synchronous to pclk; presetn is the power-on event.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module mcu_reset_control #(
    parameter int WDOG_BASE_CYCLES = 8192,
    parameter logic [2:0] MASK_OPT_INIT = rst_ctrl_pkg::MASK_OPT_RESET
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    input wire logic low_voltage_detect,
    input wire logic opcode_fetch,
    input wire logic [15:0] fetch_addr,
    output logic core_rst_n,
    output logic osc_select_low,
    output logic osc_select_high,
    output logic external_irq_enable,
    output logic [1:0] rti_rate,
    output logic comparator_direct_drive_en,
    output logic sample_offset_en,
    output logic [7:0] cpu_sp_init,
    output logic [15:0] cpu_vector_hi_addr,
    output logic [15:0] cpu_vector_lo_addr,
    output logic [15:0] timer_preset,
    output logic [7:0] analog_mux_register_init,
    output logic [7:0] cleared_init
);
    localparam int WDOG_W = 40;

    // Bus decode
    logic setup;
    logic wr_en;
    logic hit_ws;
    logic hit_mo;
    logic hit_st;
    logic hit_pc;
    logic hit_any;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign hit_ws = (paddr == rst_ctrl_pkg::ADDR_WDOG_SEC);
    assign hit_mo = (paddr == rst_ctrl_pkg::ADDR_MASK_OPT);
    assign hit_st = (paddr == rst_ctrl_pkg::ADDR_STATUS);
    assign hit_pc = (paddr == rst_ctrl_pkg::ADDR_PERIPH);
    assign hit_any = hit_ws | hit_mo | hit_st | hit_pc;

    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_any;

    // Sequencer state
    rst_ctrl_pkg::rst_state_t state_q;
    rst_ctrl_pkg::rst_state_t state_d;
    logic [11:0] dly_q;
    logic [11:0] dly_d;
    logic rst_q;
    logic rst_d;

    // Registers
    logic opt_q;
    logic opt_d;
    logic protect_q;
    logic protect_d;
    logic [2:0] mo_q;
    logic [2:0] mo_d;
    logic [4:0] pc_q;
    logic [4:0] pc_d;
    logic [4:0] cause_q;
    logic [4:0] cause_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Watchdog
    logic [WDOG_W-1:0] wd_cnt_q;
    logic [WDOG_W-1:0] wd_cnt_d;
    logic [WDOG_W-1:0] wd_limit;
    logic wd_kick;
    logic wd_fire;

    // Sources
    logic uv_src;
    logic ill_src;
    logic fetch_ok;
    logic pin_low;
    logic [2:0] src_vec;
    logic [2:0] pull_vec;
    logic any_src;

    // Software restarts the watchdog by writing zero to the clear bit
    assign wd_kick = wr_en && hit_ws
        && !pwdata[rst_ctrl_pkg::WS_CLEAR];

    // Timeout grows by four per rate step; rate 3 is the longest
    assign wd_limit = WDOG_W'(WDOG_BASE_CYCLES) << {rti_rate, 1'b0};

    // Counter runs only when the option enables the watchdog
    always_comb begin
        wd_cnt_d = wd_cnt_q;
        if (rst_q) begin
            wd_cnt_d = '0;
        end else if (wd_kick) begin
            wd_cnt_d = '0;
        end else if (mo_q[rst_ctrl_pkg::MO_WDOG_EN]) begin
            if (wd_cnt_q < wd_limit - WDOG_W'(1)) begin
                wd_cnt_d = wd_cnt_q + WDOG_W'(1);
            end else begin
                wd_cnt_d = '0;
            end
        end
    end

    // A timeout fires for one cycle, then the reset holds the counter
    assign wd_fire = !rst_q && !wd_kick
        && mo_q[rst_ctrl_pkg::MO_WDOG_EN]
        && (wd_cnt_q == wd_limit - WDOG_W'(1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt_q <= '0;
        end else begin
            wd_cnt_q <= wd_cnt_d;
        end
    end

    // Undervoltage only counts when its option is set
    assign uv_src = low_voltage_detect
        && mo_q[rst_ctrl_pkg::MO_UV_EN];

    // Legal fetches lie in program memory or RAM
    assign fetch_ok =
        (fetch_addr >= rst_ctrl_pkg::PROG_LO && fetch_addr <= rst_ctrl_pkg::PROG_HI)
        || (fetch_addr >= rst_ctrl_pkg::RAM_LO && fetch_addr <= rst_ctrl_pkg::RAM_HI);
    assign ill_src = opcode_fetch && !fetch_ok && !rst_q;

    // Only these three sources drive the pin; power-on is absent
    assign src_vec = {ill_src, uv_src, wd_fire};

    generate
        for (genvar i = 0; i < 3; i++) begin : g_pull
            pull_stretch u_pull (
                .pclk(pclk),
                .presetn(presetn),
                .src(src_vec[i]),
                .pull(pull_vec[i])
            );
        end
    endgenerate

    // Open-drain pin: drive low while any stretcher is active
    assign reset_pin_oe = |pull_vec;
    assign reset_pin_out = 1'b0;

    // Pin sampled once per edge; a shorter pulse may be missed
    assign pin_low = !reset_pin_in;

    // Own pulldown also reads back low on the pin
    assign any_src = pin_low | (|pull_vec);

    // Sequencer: power-on wait, then hold while any source lasts
    always_comb begin
        state_d = state_q;
        dly_d = dly_q;
        rst_d = rst_q;
        unique case (state_q)
            rst_ctrl_pkg::RS_POR_WAIT: begin
                rst_d = 1'b1;
                if (dly_q == 12'h001) begin
                    if (any_src) begin
                        state_d = rst_ctrl_pkg::RS_HOLD;
                    end else begin
                        state_d = rst_ctrl_pkg::RS_RUN;
                        rst_d = 1'b0;
                    end
                end else begin
                    dly_d = dly_q - 12'h001;
                end
            end
            rst_ctrl_pkg::RS_HOLD: begin
                rst_d = 1'b1;
                if (!any_src) begin
                    state_d = rst_ctrl_pkg::RS_RUN;
                    rst_d = 1'b0;
                end
            end
            rst_ctrl_pkg::RS_RUN: begin
                rst_d = 1'b0;
                if (any_src) begin
                    state_d = rst_ctrl_pkg::RS_HOLD;
                    rst_d = 1'b1;
                end
            end
            default: begin
                state_d = rst_ctrl_pkg::RS_HOLD;
                rst_d = 1'b1;
            end
        endcase
    end

    // Delay length is captured from the option after power-on
    logic dly_loaded_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= rst_ctrl_pkg::RS_POR_WAIT;
            dly_q <= rst_ctrl_pkg::DELAY_LONG;
            dly_loaded_q <= 1'b0;
            rst_q <= 1'b1;
        end else begin
            state_q <= state_d;
            rst_q <= rst_d;
            dly_loaded_q <= 1'b1;
            if (!dly_loaded_q) begin
                dly_q <= mo_q[rst_ctrl_pkg::MO_LONG_DELAY]
                    ? rst_ctrl_pkg::DELAY_LONG
                    : rst_ctrl_pkg::DELAY_SHORT;
            end else begin
                dly_q <= dly_d;
            end
        end
    end

    assign core_rst_n = !rst_q;

    // Register writes; internal reset restores opt_q and pc_q but keeps protect_q
    always_comb begin
        opt_d = opt_q;
        protect_d = protect_q;
        mo_d = mo_q;
        pc_d = pc_q;
        if (rst_q) begin
            opt_d = 1'b0;
            pc_d = rst_ctrl_pkg::PERIPH_RESET;
        end else if (wr_en && hit_ws) begin
            opt_d = pwdata[rst_ctrl_pkg::WS_OPT];
            protect_d = protect_q | pwdata[rst_ctrl_pkg::WS_PROTECT];
        end else if (wr_en && hit_pc) begin
            pc_d = pwdata[4:0];
        end
        // Options survive the internal reset, as fuses would
        if (wr_en && hit_mo) begin
            mo_d = pwdata[2:0];
        end
    end

    // Sticky causes: a new event wins over a write-one clear
    always_comb begin
        cause_d = cause_q;
        if (wr_en && hit_st) begin
            cause_d = cause_q & ~pwdata[4:0];
        end
        if (pin_low) begin
            cause_d[rst_ctrl_pkg::ST_PIN] = 1'b1;
        end
        if (wd_fire) begin
            cause_d[rst_ctrl_pkg::ST_WDOG] = 1'b1;
        end
        if (uv_src) begin
            cause_d[rst_ctrl_pkg::ST_UV] = 1'b1;
        end
        if (ill_src) begin
            cause_d[rst_ctrl_pkg::ST_ILLEGAL] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_q <= 1'b0;
            protect_q <= 1'b0;
            mo_q <= MASK_OPT_INIT;
            pc_q <= rst_ctrl_pkg::PERIPH_RESET;
            cause_q <= 5'h01;
        end else begin
            opt_q <= opt_d;
            protect_q <= protect_d;
            mo_q <= mo_d;
            pc_q <= pc_d;
            cause_q <= cause_d;
        end
    end

    // Read data captured in the setup phase; clear bit reads zero
    always_comb begin
        rdata_d = rdata_q;
        if (setup && !pwrite) begin
            rdata_d = 32'h0;
            if (hit_ws) begin
                rdata_d[rst_ctrl_pkg::WS_OPT] = opt_q;
                rdata_d[rst_ctrl_pkg::WS_PROTECT] = protect_q;
            end else if (hit_mo) begin
                rdata_d[2:0] = mo_q;
            end else if (hit_st) begin
                rdata_d[4:0] = cause_q;
                rdata_d[rst_ctrl_pkg::ST_IN_RESET] = rst_q;
                rdata_d[rst_ctrl_pkg::ST_PULLDOWN] = reset_pin_oe;
            end else if (hit_pc) begin
                rdata_d[4:0] = pc_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata = rdata_q;

    // Peripheral controls straight from their register bits
    assign osc_select_low = pc_q[rst_ctrl_pkg::PC_OSC_LOW];
    assign osc_select_high = pc_q[rst_ctrl_pkg::PC_OSC_HIGH];
    assign external_irq_enable = pc_q[rst_ctrl_pkg::PC_IRQ_EN];
    assign rti_rate = pc_q[rst_ctrl_pkg::PC_RTI_HI:rst_ctrl_pkg::PC_RTI_LO];
    assign comparator_direct_drive_en = opt_q;
    assign sample_offset_en = opt_q;

    // Reset image for CPU and peripherals; held in flops so the
    // values are stable while core_rst_n is low
    logic [7:0] sp_q;
    logic [15:0] vhi_q;
    logic [15:0] vlo_q;
    logic [15:0] tmr_q;
    logic [7:0] analog_mux_register_q;
    logic [7:0] clr_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_q <= rst_ctrl_pkg::SP_RESET;
            vhi_q <= rst_ctrl_pkg::VECTOR_HI_ADDR;
            vlo_q <= rst_ctrl_pkg::VECTOR_LO_ADDR;
            tmr_q <= rst_ctrl_pkg::TIMER_PRESET;
            analog_mux_register_q <= rst_ctrl_pkg::ANALOG_MUX_REGISTER_RESET;
            clr_q <= rst_ctrl_pkg::CLEARED;
        end else if (rst_q) begin
            sp_q <= rst_ctrl_pkg::SP_RESET;
            vhi_q <= rst_ctrl_pkg::VECTOR_HI_ADDR;
            vlo_q <= rst_ctrl_pkg::VECTOR_LO_ADDR;
            tmr_q <= rst_ctrl_pkg::TIMER_PRESET;
            analog_mux_register_q <= rst_ctrl_pkg::ANALOG_MUX_REGISTER_RESET;
            clr_q <= rst_ctrl_pkg::CLEARED;
        end
    end

    // Peripherals apply these only while core_rst_n is low, which
    // leaves data, capture and compare registers untouched
    assign cpu_sp_init = sp_q;
    assign cpu_vector_hi_addr = vhi_q;
    assign cpu_vector_lo_addr = vlo_q;
    assign timer_preset = tmr_q;
    assign analog_mux_register_init = analog_mux_register_q;
    assign cleared_init = clr_q;
endmodule : mcu_reset_control

// ---- test/mcu_reset_control_props.sv ----
// Port checker for the reset controller.
// Assumes one pclk domain; bound from the bench top file.
`timescale 1ns/1ps
module mcu_reset_control_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic reset_pin_in,
    input wire logic reset_pin_oe,
    input wire logic low_voltage_detect,
    input wire logic core_rst_n,
    input wire logic osc_select_low,
    input wire logic osc_select_high,
    input wire logic external_irq_enable,
    input wire logic [1:0] rti_rate,
    input wire logic comparator_direct_drive_en,
    input wire logic sample_offset_en,
    input wire logic [7:0] cpu_sp_init,
    input wire logic [15:0] timer_preset,
    input wire logic [7:0] analog_mux_register_init
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Power-on alone must leave the pin alone, so no reset disable here
    por_no_pull_a: assert property (disable iff (1'b0) !presetn |-> !reset_pin_oe)
        else $error("pulldown on during power-on");
    pull_min_a: assert property ($rose(reset_pin_oe) |-> reset_pin_oe[*3])
        else $error("pulldown shorter than three cycles");
    pull_max_a: assert property ($rose(reset_pin_oe) ##1 (!low_voltage_detect)[*4]
        |-> !reset_pin_oe)
        else $error("pulldown longer than four cycles");
    pull_rst_a: assert property (reset_pin_oe |=> !core_rst_n)
        else $error("pulldown without internal reset");
    pin_rst_a: assert property (!reset_pin_in |=> !core_rst_n)
        else $error("low pin without internal reset");
    rst_release_a: assert property ($rose(core_rst_n)
        |-> $past(reset_pin_in) && !$past(reset_pin_oe))
        else $error("release while a source is active");
    reset_image_a: assert property (!core_rst_n ##1 !core_rst_n |->
        !osc_select_low && osc_select_high && external_irq_enable && rti_rate == 2'h3)
        else $error("peripheral image wrong in reset");
    opt_pair_a: assert property (comparator_direct_drive_en == sample_offset_en)
        else $error("optional features disagree");
    opt_clr_a: assert property (!core_rst_n ##1 !core_rst_n
        |-> !comparator_direct_drive_en)
        else $error("optional features kept in reset");
    image_const_a: assert property (
        cpu_sp_init == 8'hff && timer_preset == 16'hfffc && analog_mux_register_init == 8'h80)
        else $error("reset image constant wrong");
    // Main scenarios reached
    cover property ($rose(reset_pin_oe));
    cover property ($rose(core_rst_n));
    cover property (comparator_direct_drive_en);
endmodule : mcu_reset_control_props

// ---- test/reset_pin_partner.sv ----
// Reset pin with pull-up and supply monitor beside the controller.
// Assumes the bench raises ext_req and dip_req right after pclk edges.
`timescale 1ns/1ps
module reset_pin_partner (
    input wire logic pclk,
    input wire logic ext_req,
    input wire logic dip_req,
    input wire logic pin_oe,
    input wire logic pin_out,
    output logic pin_level,
    output logic low_voltage_detect
);
    logic [1:0] hold_q = 2'h0;
    logic lvd_q = 1'b0;
    // External low stretched to two cycles, above the minimum width
    always_ff @(posedge pclk) begin
        hold_q <= ext_req ? 2'h2 : (hold_q != 2'h0 ? hold_q - 2'h1 : 2'h0);
        lvd_q <= dip_req;
    end
    // Wired pin: pull-up wins unless a party drives low
    assign pin_level = !((pin_oe && !pin_out) || hold_q != 2'h0);
    assign low_voltage_detect = lvd_q;
endmodule : reset_pin_partner

// ---- test/tb_mcu_reset_control.sv ----
// Self-checking bench for the reset controller and its pin partner.
// Assumes zero-wait APB answers; the checker is bound at the foot.
`timescale 1ns/1ps
module tb_mcu_reset_control;
    logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000, fetch_addr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rd, v;
    logic pready, pslverr, err, pin, pin_out, pin_oe, lvd, core_rst_n, osl, osh, irq_en;
    logic opcode_fetch = 1'b0, ext_req = 1'b0, dip_req = 1'b0, cdd, soe;
    logic [1:0] rti;
    logic [7:0] sp, analog_mux_register, clr;
    logic [15:0] vhi, vlo, tpre;
    logic [15:0] addrs [10] = '{16'h0700, 16'h1fff, 16'h0020, 16'h00ff, 16'h06ff,
        16'h2000, 16'h001f, 16'h0100, 16'hffff, 16'h0000};
    int fail_count = 0, n_compared = 0, cyc = 0, seed = 31, t, l, n;

    mcu_reset_control #(.WDOG_BASE_CYCLES(4), .MASK_OPT_INIT(3'h6)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reset_pin_in(pin),
        .reset_pin_out(pin_out), .reset_pin_oe(pin_oe), .low_voltage_detect(lvd),
        .opcode_fetch(opcode_fetch), .fetch_addr(fetch_addr), .core_rst_n(core_rst_n),
        .osc_select_low(osl), .osc_select_high(osh), .external_irq_enable(irq_en),
        .rti_rate(rti), .comparator_direct_drive_en(cdd), .sample_offset_en(soe),
        .cpu_sp_init(sp), .cpu_vector_hi_addr(vhi), .cpu_vector_lo_addr(vlo),
        .timer_preset(tpre), .analog_mux_register_init(analog_mux_register), .cleared_init(clr));
    reset_pin_partner u_pin (.pclk(pclk), .ext_req(ext_req), .dip_req(dip_req),
        .pin_oe(pin_oe), .pin_out(pin_out), .pin_level(pin), .low_voltage_detect(lvd));

    always #5 pclk = ~pclk;
    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic close_out;
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One APB transfer; ends at a falling edge so outputs have settled
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : apb

    // Cycles until the pulldown turns on (t), then how long it stays (l)
    task automatic wait_oe(input int lim);
        t = 0;
        while (pin_oe !== 1'b1 && t < lim) begin
            @(negedge pclk);
            t++;
        end
        for (l = 0; pin_oe === 1'b1; l++) @(negedge pclk);
    endtask : wait_oe

    task automatic wait_run;
        while (core_rst_n !== 1'b1) @(negedge pclk);
    endtask : wait_run

    task automatic pulse_lvd(input int len);
        @(posedge pclk);
        fork
            wait_oe(20);
            begin
                dip_req <= 1'b1;
                repeat (len) @(posedge pclk);
                dip_req <= 1'b0;
            end
        join
    endtask : pulse_lvd

    function automatic logic legal(input logic [15:0] a);
        return (a >= 16'h0700 && a <= 16'h1fff) || (a >= 16'h0020 && a <= 16'h00ff);
    endfunction : legal

    initial begin
        // Starts high so the drop at time zero resets every controller flop at once
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (t = 0; core_rst_n !== 1'b1; t++) @(negedge pclk);
        chk("por_delay", t >= 16 && t <= 19, 1);
        apb(1'b0, 16'h1f08, 32'h0);
        chk("periph_image", rd, 32'h1e);
        chk("vectors", {vhi, vlo}, 32'h1ffe1fff);
        chk("cleared", clr, 32'h0);
        apb(1'b0, 16'h1f0c, 32'h0);
        chk("unmapped", err, 1);
        // Kicks carry random optional-feature settings
        repeat (6) begin
            v = $random(seed);
            apb(1'b1, 16'h1ff0, {30'h0, v[1], 1'b0});
            chk("opt_en", cdd, {31'h0, v[1]});
            repeat (150) @(posedge pclk);
        end
        apb(1'b0, 16'h1ff0, 32'h0);
        chk("clear_reads", rd[0], 0);
        apb(1'b1, 16'h1ff0, 32'h3);
        wait_oe(300);
        chk("one_ignored", t >= 90 && t <= 110, 1);
        chk("wdog_pull", l >= 3 && l <= 4, 1);
        wait_run();
        chk("opt_reset", cdd, 0);
        apb(1'b0, 16'h1f04, 32'h0);
        chk("wdog_cause", rd[2], 1);
        wait_oe(400);
        chk("full_period", t >= 240 && t <= 262, 1);
        wait_run();
        apb(1'b1, 16'h1f00, 32'h4);
        wait_oe(400);
        chk("wdog_off", l, 0);
        // Watchdog is off, so a short rate here cannot cause resets
        v = $random(seed);
        apb(1'b1, 16'h1f08, {27'h0, v[4:0]});
        chk("periph_wr", {rti, irq_en, osh, osl}, {27'h0, v[4:0]});
        apb(1'b1, 16'h1f04, 32'h1f);
        apb(1'b0, 16'h1f04, 32'h0);
        chk("cause_clear", rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            n = (i == 0) ? 1 : 1 + ($unsigned($random(seed)) % 8);
            pulse_lvd(n);
            chk("lvd_pull", l >= (n > 3 ? n : 3) && l <= (n > 4 ? n : 4), 1);
            wait_run();
        end
        // The undervoltage resets above must have restored the image
        apb(1'b0, 16'h1f08, 32'h0);
        chk("periph_back", rd, 32'h1e);
        apb(1'b1, 16'h1f00, 32'h0);
        pulse_lvd(6);
        chk("lvd_off", l, 0);
        for (int i = 0; i < 14; i++) begin
            v = (i < 10) ? {16'h0, addrs[i]} : $random(seed);
            @(posedge pclk);
            fork
                wait_oe(6);
                begin
                    opcode_fetch <= 1'b1;
                    fetch_addr <= v[15:0];
                    @(posedge pclk);
                    opcode_fetch <= 1'b0;
                end
            join
            chk("fetch", l != 0, !legal(v[15:0]));
            wait_run();
        end
        @(posedge pclk);
        ext_req <= 1'b1;
        @(posedge pclk);
        ext_req <= 1'b0;
        repeat (3) @(negedge pclk);
        chk("pin_reset", core_rst_n, 0);
        wait_run();
        // Second power-on with the pin held low past the short delay
        @(posedge pclk);
        presetn <= 1'b0;
        ext_req <= 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        fork
            for (t = 0; core_rst_n !== 1'b1; t++) @(negedge pclk);
            begin
                repeat (40) @(posedge pclk);
                ext_req <= 1'b0;
            end
        join
        chk("held_release", t >= 41 && t <= 46, 1);
        close_out();
    end
endmodule : tb_mcu_reset_control

bind mcu_reset_control mcu_reset_control_props u_props (.pclk(pclk), .presetn(presetn),
    .reset_pin_in(reset_pin_in), .reset_pin_oe(reset_pin_oe),
    .low_voltage_detect(low_voltage_detect), .core_rst_n(core_rst_n),
    .osc_select_low(osc_select_low), .osc_select_high(osc_select_high),
    .external_irq_enable(external_irq_enable), .rti_rate(rti_rate),
    .comparator_direct_drive_en(comparator_direct_drive_en),
    .sample_offset_en(sample_offset_en), .cpu_sp_init(cpu_sp_init),
    .timer_preset(timer_preset), .analog_mux_register_init(analog_mux_register_init));
